/* File: shared/lgp_consts.vh */
// constants for the led and pin configuration register block
`ifndef LGP_CONSTS_VH
`define LGP_CONSTS_VH

// register map, byte addresses
`define LGP_ADDR_W            8
`define LGP_OFS_LED_PIN_CFG   8'h24

// field positions
`define LGP_LED_FUNCTION_SELECT_ALT_BIT       31
`define LGP_P10_FN_HI         25
`define LGP_P10_FN_LO         24
`define LGP_P9_FN_HI          21
`define LGP_P9_FN_LO          20
`define LGP_P8_FN_HI          17
`define LGP_P8_FN_LO          16
`define LGP_DRV_HI            10
`define LGP_DRV_LO            8
`define LGP_DIR_HI            6
`define LGP_DIR_LO            4
`define LGP_DAT_HI            2
`define LGP_DAT_LO            0

// reset values
`define LGP_RST_LED_FUNCTION_SELECT_ALT       1'h0
`define LGP_RST_FN            2'h0
`define LGP_RST_DRV           3'h0
`define LGP_RST_DIR           3'h0
`define LGP_RST_DATA          3'h0
`define LGP_RST_RDATA         32'h00000000

// pin function codes
`define LGP_FN_GPIO           2'h0
`define LGP_FN_LED            2'h1
`define LGP_FN_MIRROR_A       2'h2
`define LGP_FN_MIRROR_B       2'h3

// bus answer timing: cycles from request sampled to waitrequest low
`define LGP_ACK_CYCLES        1

`endif

/* File: src/lgp_led_pin_cfg.v */
// led and general purpose pin 8..10 configuration register with avalon-mm slave
//
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/1ps
`include "lgp_consts.vh"

module lgp_led_pin_cfg #(
  parameter LED_BY_SELECT = 1  // 0: code 01 fixed leds, 1: leds follow select bit
) (
  input  wire        CORE_CLK,
  input  wire        RESETN,
  // avalon-mm slave
  input  wire [7:0]  AVS_ADDRESS,
  input  wire        AVS_READ,
  input  wire        AVS_WRITE,
  input  wire [31:0] AVS_WRITEDATA,
  input  wire [3:0]  AVS_BYTEENABLE,
  output wire [31:0] AVS_READDATA,
  output wire        AVS_WAITREQUEST,
  // eeprom image and soft resets, same clock
  input  wire        EEPROM_PRESENT,
  input  wire        EEPROM_LED_FUNCTION_SELECT_ALT,
  input  wire        USB_RESET,
  input  wire        LITE_RESET,
  // link status, same clock
  input  wire        LINK_UP,
  input  wire        LINK_SPEED_100,
  input  wire        LINK_FULL_DUPLEX,
  input  wire        LINK_ACTIVITY,
  // internal mii and phy reset, other domain
  input  wire [3:0]  MII_RXD,
  input  wire        MII_CRS,
  input  wire        PHY_RESET_N,
  // wake enable from separate register, same clock
  input  wire [2:0]  PIN_WAKE_EN,
  // pins 8..10, bit 0 is pin 8
  input  wire [2:0]  PIN_IN,
  output wire [2:0]  PIN_OUT,
  output wire [2:0]  PIN_OE,
  // dedicated led pins, active low
  output wire        SPEED_LED_N,
  output wire        LINK_ACTIVITY_LED_N,
  output wire        DUPLEX_LED_N,
  // events
  output wire [2:0]  PIN_EVENT,
  output wire [2:0]  PIN_WAKE
);

  // register fields
  reg        led_function_select_r;
  reg [1:0]  pin10_function_code_r;
  reg [1:0]  pin9_function_code_r;
  reg [1:0]  pin8_function_code_r;
  reg [2:0]  pin_drive_type_r;
  reg [2:0]  pin_direction_r;
  reg [2:0]  pin_data_r;
  reg        sel_load_pend_r;

  // bus state
  reg        waitreq_r;
  reg [31:0] rdata_r;

  // synchronisers
  reg [2:0]  pin_meta_r;
  reg [2:0]  pin_level_r;
  reg [2:0]  pin_prev_r;
  reg [5:0]  mir_meta_r;
  reg [5:0]  mir_sync_r;

  // output flops
  reg [2:0]  pin_out_r;
  reg [2:0]  pin_oe_r;
  reg        spd_led_n_r;
  reg        lnk_led_n_r;
  reg        fdx_led_n_r;
  reg [2:0]  pin_event_r;
  reg [2:0]  pin_wake_r;

  // combinational helpers
  reg [2:0]  pin_out_nxt;
  reg [2:0]  pin_oe_nxt;
  reg [2:0]  drive_val;
  reg [2:0]  drive_on;
  reg        led2_on;
  reg        led3_on;
  wire       bus_req;
  wire       hit;
  wire       wr_take;
  wire [31:0] cfg_view;
  wire [7:0] data_lane;

  // merge byte lanes of a write into a field
  function [7:0] lane_merge;
    input [7:0] old_v;
    input [7:0] new_v;
    input       en;
    begin
      lane_merge = en ? new_v : old_v;
    end
  endfunction

  // resolve one pin buffer: push-pull or open-drain
  function [1:0] pad_drive;  // {oe, out}
    input want_drive;
    input val;
    input push_pull;
    begin
      if (!want_drive)
        pad_drive = 2'h0;
      else if (push_pull)
        pad_drive = {1'b1, val};
      else
        pad_drive = {~val, 1'b0};  // open-drain only pulls low
    end
  endfunction

  assign bus_req = AVS_READ | AVS_WRITE;
  assign hit     = (AVS_ADDRESS == `LGP_OFS_LED_PIN_CFG);
  // a write commits only at the edge where waitrequest is seen low
  assign wr_take = AVS_WRITE & ~waitreq_r & hit;

  // read view; reserved bits are constant zero
  assign cfg_view = {led_function_select_r, 5'h00,
                     pin10_function_code_r, 2'h0,
                     pin9_function_code_r, 2'h0,
                     pin8_function_code_r, 5'h00,
                     pin_drive_type_r, 1'b0,
                     pin_direction_r, 1'b0,
                     pin_level_r};

  // low lane of a write merged over the current data bits
  assign data_lane = lane_merge({5'h00, pin_data_r}, AVS_WRITEDATA[7:0], AVS_BYTEENABLE[0]);

  // two-flop synchronisers; first stage feeds only the second
  // pin stages reset to the pulled-up idle level, so no false event after reset
  always @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      pin_meta_r  <= 3'h7;
      pin_level_r <= 3'h7;
      pin_prev_r  <= 3'h7;
      mir_meta_r  <= 6'h00;
      mir_sync_r  <= 6'h00;
    end else begin
      pin_meta_r  <= PIN_IN;
      pin_level_r <= pin_meta_r;
      pin_prev_r  <= pin_level_r;
      mir_meta_r  <= {PHY_RESET_N, MII_CRS, MII_RXD};
      mir_sync_r  <= mir_meta_r;
    end
  end

  // bus handshake: one wait cycle, then a single-cycle low waitrequest
  always @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      waitreq_r <= 1'b1;
      rdata_r   <= `LGP_RST_RDATA;
    end else begin
      if (bus_req && waitreq_r) begin
        waitreq_r <= 1'b0;
        // unmapped addresses read as zero
        rdata_r   <= (AVS_READ && hit) ? cfg_view : `LGP_RST_RDATA;
      end else begin
        waitreq_r <= 1'b1;
      end
    end
  end

  // led select: async reset to 0, image loaded on the first clock after release
  always @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      led_function_select_r <= `LGP_RST_LED_FUNCTION_SELECT_ALT;
      sel_load_pend_r       <= 1'b1;
    end else begin
      sel_load_pend_r <= 1'b0;
      if (sel_load_pend_r || USB_RESET || LITE_RESET) begin
        // soft resets beat a concurrent write
        led_function_select_r <= EEPROM_PRESENT ? EEPROM_LED_FUNCTION_SELECT_ALT
                                                : `LGP_RST_LED_FUNCTION_SELECT_ALT;
      end else if (wr_take && AVS_BYTEENABLE[3]) begin
        led_function_select_r <= AVS_WRITEDATA[`LGP_LED_FUNCTION_SELECT_ALT_BIT];
      end
    end
  end

  // configuration fields
  always @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      pin10_function_code_r <= `LGP_RST_FN;
      pin9_function_code_r  <= `LGP_RST_FN;
      pin8_function_code_r  <= `LGP_RST_FN;
      pin_drive_type_r      <= `LGP_RST_DRV;
      pin_direction_r       <= `LGP_RST_DIR;
    end else if (wr_take) begin
      if (AVS_BYTEENABLE[3])
        pin10_function_code_r <= AVS_WRITEDATA[`LGP_P10_FN_HI:`LGP_P10_FN_LO];
      if (AVS_BYTEENABLE[2]) begin
        pin9_function_code_r <= AVS_WRITEDATA[`LGP_P9_FN_HI:`LGP_P9_FN_LO];
        pin8_function_code_r <= AVS_WRITEDATA[`LGP_P8_FN_HI:`LGP_P8_FN_LO];
      end
      if (AVS_BYTEENABLE[1])
        pin_drive_type_r <= AVS_WRITEDATA[`LGP_DRV_HI:`LGP_DRV_LO];
      if (AVS_BYTEENABLE[0])
        pin_direction_r <= AVS_WRITEDATA[`LGP_DIR_HI:`LGP_DIR_LO];
    end
  end

  // data bits: input pins track the pin level so an output starts from it;
  // output pins hold the written value
  always @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      pin_data_r <= `LGP_RST_DATA;
    end else begin
      pin_data_r <= (pin_level_r & ~pin_direction_r) |
                    (pin_data_r & pin_direction_r);
      if (wr_take && AVS_BYTEENABLE[0])
        pin_data_r <= data_lane[`LGP_DAT_HI:`LGP_DAT_LO];
    end
  end

  // led indications for the current select setting
  always @* begin
    if (led_function_select_r) begin
      led2_on = LINK_UP;
      led3_on = LINK_ACTIVITY;
    end else begin
      led2_on = LINK_UP & ~LINK_ACTIVITY;       // link on, blinks off on traffic
      led3_on = LINK_ACTIVITY;
    end
  end

  // per-pin function mux
  always @* begin
    drive_val = pin_data_r;
    drive_on  = pin_direction_r;
    // pin 10
    case (pin10_function_code_r)
      `LGP_FN_GPIO:     begin drive_on[2] = pin_direction_r[2]; end
      `LGP_FN_LED:      begin drive_on[2] = 1'b1; drive_val[2] = ~LINK_SPEED_100; end
      `LGP_FN_MIRROR_A: begin drive_on[2] = 1'b1; drive_val[2] = mir_sync_r[0]; end
      `LGP_FN_MIRROR_B: begin drive_on[2] = 1'b1; drive_val[2] = mir_sync_r[3]; end
      default:          begin drive_on[2] = 1'b0; end
    endcase
    // pin 9
    case (pin9_function_code_r)
      `LGP_FN_GPIO:     begin drive_on[1] = pin_direction_r[1]; end
      `LGP_FN_LED:      begin
        drive_on[1]  = 1'b1;
        drive_val[1] = (LED_BY_SELECT != 0) ? ~led2_on : ~(LINK_UP & ~LINK_ACTIVITY);
      end
      `LGP_FN_MIRROR_A: begin drive_on[1] = 1'b1; drive_val[1] = mir_sync_r[1]; end
      `LGP_FN_MIRROR_B: begin drive_on[1] = 1'b1; drive_val[1] = mir_sync_r[5]; end
      default:          begin drive_on[1] = 1'b0; end
    endcase
    // pin 8
    case (pin8_function_code_r)
      `LGP_FN_GPIO:     begin drive_on[0] = pin_direction_r[0]; end
      `LGP_FN_LED:      begin
        drive_on[0]  = 1'b1;
        drive_val[0] = (LED_BY_SELECT != 0) ? ~led3_on : ~(LINK_UP & LINK_FULL_DUPLEX);
      end
      `LGP_FN_MIRROR_A: begin drive_on[0] = 1'b1; drive_val[0] = mir_sync_r[2]; end
      `LGP_FN_MIRROR_B: begin drive_on[0] = 1'b1; drive_val[0] = mir_sync_r[4]; end
      default:          begin drive_on[0] = 1'b0; end
    endcase
  end

  // buffer type applies to every function
  always @* begin
    {pin_oe_nxt[0], pin_out_nxt[0]} = pad_drive(drive_on[0], drive_val[0], pin_drive_type_r[0]);
    {pin_oe_nxt[1], pin_out_nxt[1]} = pad_drive(drive_on[1], drive_val[1], pin_drive_type_r[1]);
    {pin_oe_nxt[2], pin_out_nxt[2]} = pad_drive(drive_on[2], drive_val[2], pin_drive_type_r[2]);
  end

  // registered pin, led and event outputs
  always @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      pin_out_r   <= 3'h0;
      pin_oe_r    <= 3'h0;
      spd_led_n_r <= 1'b1;
      lnk_led_n_r <= 1'b1;
      fdx_led_n_r <= 1'b1;
      pin_event_r <= 3'h0;
      pin_wake_r  <= 3'h0;
    end else begin
      pin_out_r   <= pin_out_nxt;
      pin_oe_r    <= pin_oe_nxt;
      spd_led_n_r <= ~(LINK_UP & LINK_SPEED_100);
      lnk_led_n_r <= ~led2_on;
      fdx_led_n_r <= ~led3_on;
      // a level change on a gpio input is the event; outputs never fire
      pin_event_r <= (pin_level_r ^ pin_prev_r) & ~pin_direction_r
                     & {pin10_function_code_r == `LGP_FN_GPIO,
                        pin9_function_code_r == `LGP_FN_GPIO,
                        pin8_function_code_r == `LGP_FN_GPIO};
      pin_wake_r  <= (pin_level_r ^ pin_prev_r) & ~pin_direction_r
                     & PIN_WAKE_EN
                     & {pin10_function_code_r == `LGP_FN_GPIO,
                        pin9_function_code_r == `LGP_FN_GPIO,
                        pin8_function_code_r == `LGP_FN_GPIO};
    end
  end

  assign AVS_READDATA        = rdata_r;
  assign AVS_WAITREQUEST     = waitreq_r;
  assign PIN_OUT             = pin_out_r;
  assign PIN_OE              = pin_oe_r;
  assign SPEED_LED_N         = spd_led_n_r;
  assign LINK_ACTIVITY_LED_N = lnk_led_n_r;
  assign DUPLEX_LED_N        = fdx_led_n_r;
  assign PIN_EVENT           = pin_event_r;
  assign PIN_WAKE            = pin_wake_r;

endmodule // lgp_led_pin_cfg

/* File: testbench/lgp_pad_model.sv */
// board side of pins 8..10: pull-ups plus an optional board driver
`timescale 1ns/1ps
module lgp_pad_model (
  input  wire [2:0] pin_out,
  input  wire [2:0] pin_oe,
  input  wire [2:0] ext_en,
  input  wire [2:0] ext_val,
  output wire [2:0] pad
);
  // released pins float up, so an open-drain high never reads stale
  assign pad = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) | (~pin_oe & ~ext_en);
endmodule // lgp_pad_model

/* File: testbench/lgp_led_pin_cfg_chk.sv */
// port checker for the led and pin configuration block
`timescale 1ns/1ps
module lgp_cfg_chk (
  input wire        CORE_CLK,
  input wire        RESETN,
  input wire        AVS_READ,
  input wire        AVS_WRITE,
  input wire [31:0] AVS_READDATA,
  input wire        AVS_WAITREQUEST,
  input wire        LINK_UP,
  input wire        LINK_SPEED_100,
  input wire        LINK_ACTIVITY,
  input wire [2:0]  PIN_OE,
  input wire [2:0]  PIN_EVENT,
  input wire [2:0]  PIN_WAKE,
  input wire        SPEED_LED_N,
  input wire        DUPLEX_LED_N
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);
  // bus answer timing and read data hold
  property p_ans; (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST; endproperty
  a_ans: assert property (p_ans) else $error("bus answer late");
  property p_idle; !(AVS_READ || AVS_WRITE) |=> AVS_WAITREQUEST; endproperty
  a_idle: assert property (p_idle) else $error("answer without request");
  property p_hold; AVS_WAITREQUEST |-> $stable(AVS_READDATA); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_rsv; !AVS_WAITREQUEST |-> (AVS_READDATA & 32'h7CCCF888) == 32'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit set");
  // events only from input pins, wake only with an event
  property p_evin; (PIN_EVENT & PIN_OE) == 3'h0; endproperty
  a_evin: assert property (p_evin) else $error("event on driven pin");
  property p_wake; (PIN_WAKE & ~PIN_EVENT) == 3'h0; endproperty
  a_wake: assert property (p_wake) else $error("wake without event");
  // led pins are registered one cycle behind link status
  property p_spd; LINK_UP && LINK_SPEED_100 |=> !SPEED_LED_N; endproperty
  a_spd: assert property (p_spd) else $error("speed led off");
  property p_dpx; LINK_UP && LINK_ACTIVITY |=> !DUPLEX_LED_N; endproperty
  a_dpx: assert property (p_dpx) else $error("activity led off");
  c_rd: cover property (AVS_READ && !AVS_WAITREQUEST);
  c_ev: cover property (PIN_EVENT != 3'h0);
  c_wk: cover property (PIN_WAKE != 3'h0);
endmodule // lgp_cfg_chk
bind lgp_led_pin_cfg lgp_cfg_chk u_chk (.*);

/* File: testbench/tb_led_gpio_pin_config.sv */
// self-checking bench for the led and pin configuration block
`timescale 1ns/1ps
`define CHK(g,e) begin comparisons++; if ((g) !== (e)) begin err_total++; \
  $display("ERROR %0t: got %h exp %h", $time, (g), (e)); end end
module tb_led_gpio_pin_config;
  logic        CORE_CLK = 0, RESETN = 0, AVS_READ = 0, AVS_WRITE = 0;
  logic        EEPROM_PRESENT = 1, EEPROM_LED_FUNCTION_SELECT_ALT = 1, USB_RESET = 0, LITE_RESET = 0;
  logic        LINK_UP = 0, LINK_SPEED_100 = 0, LINK_FULL_DUPLEX = 0, LINK_ACTIVITY = 0;
  logic        MII_CRS = 0, PHY_RESET_N = 1;
  logic [3:0]  MII_RXD = 4'h0, AVS_BYTEENABLE = 4'hF;
  logic [7:0]  AVS_ADDRESS = 8'h24;
  logic [31:0] AVS_WRITEDATA = 32'h0, q;
  logic [2:0]  PIN_WAKE_EN = 3'h0, ext_en = 3'h0, ext_val = 3'h0, ev, wk;
  wire  [31:0] AVS_READDATA;
  wire  [2:0]  PIN_IN, PIN_OUT, PIN_OE, PIN_EVENT, PIN_WAKE;
  wire         AVS_WAITREQUEST, SPEED_LED_N, LINK_ACTIVITY_LED_N, DUPLEX_LED_N;
  int          err_total = 0, comparisons = 0;

  lgp_led_pin_cfg #(.LED_BY_SELECT(1)) DUT (.*);
  lgp_pad_model u_pad (.pin_out(PIN_OUT), .pin_oe(PIN_OE), .ext_en(ext_en),
                       .ext_val(ext_val), .pad(PIN_IN));

  initial forever #25 CORE_CLK = ~CORE_CLK;
  // whole run is a few hundred cycles, so 3000 means a hang
  initial begin
    #150000;
    err_total++;
    conclude();
  end

  task automatic conclude;
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge CORE_CLK);
  endtask

  // one avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge CORE_CLK);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_WRITE <= wr;
    AVS_READ <= !wr;
    n = 0;
    do begin
      @(posedge CORE_CLK);
      n++;
    end while (AVS_WAITREQUEST !== 1'b0 && n < 20);
    `CHK(n < 20, 1'b1)
    q = AVS_READDATA;
    AVS_READ <= 0;
    AVS_WRITE <= 0;
  endtask

  task automatic srst(input logic pres, input logic usb);
    EEPROM_PRESENT <= pres;
    USB_RESET <= usb;
    LITE_RESET <= !usb;
    cyc(1);
    USB_RESET <= 0;
    LITE_RESET <= 0;
  endtask

  task automatic s_fields;
    bus(1, 8'h24, 32'hFFFFFFFF);
    cyc(8);
    bus(0, 8'h24, 32'h0);
    `CHK(q, 32'h83330772)
    bus(1, 8'h28, 32'h0);
    bus(0, 8'h28, 32'h0);
    `CHK(q, 32'h0)
    srst(0, 1);
    bus(0, 8'h24, 32'h0);
    `CHK(q, 32'h03330772)
    srst(1, 0);
    bus(0, 8'h24, 32'h0);
    `CHK(q, 32'h83330772)
  endtask

  task automatic mir(input logic [31:0] c, input logic [3:0] r, input logic s, p,
                     input logic [2:0] e);
    bus(1, 8'h24, c);
    MII_RXD <= r;
    MII_CRS <= s;
    PHY_RESET_N <= p;
    cyc(6);
    `CHK({PIN_OE, PIN_OUT}, {3'h7, e})
  endtask

  task automatic s_drive;
    bus(1, 8'h24, 32'h00000072);
    cyc(6);
    `CHK({PIN_OE, PIN_OUT & 3'b101}, 6'b101000)
    bus(0, 8'h24, 32'h0);
    `CHK(q, 32'h00000072)
    bus(1, 8'h24, 32'h00000772);
    cyc(4);
    `CHK({PIN_OE, PIN_OUT}, 6'b111010)
  endtask

  task automatic watch;
    ev = 0;
    wk = 0;
    repeat (8) begin
      @(posedge CORE_CLK);
      ev |= PIN_EVENT;
      wk |= PIN_WAKE;
    end
  endtask

  // settle pads first: leaving output mode may itself raise an event
  task automatic s_event;
    ext_val <= 3'b111;
    ext_en <= 3'b111;
    PIN_WAKE_EN <= 3'b001;
    bus(1, 8'h24, 32'h0);
    cyc(8);
    ext_val <= 3'b110;
    watch;
    `CHK({ev, wk}, 6'b001001)
    ext_val <= 3'b100;
    watch;
    `CHK({ev, wk}, 6'b010000)
    bus(1, 8'h24, 32'h00000011);
    cyc(6);
    ext_val <= 3'b101;
    watch;
    `CHK(ev, 3'b000)
    ext_en <= 3'b000;
    cyc(8);
  endtask

  task automatic s_led;
    LINK_UP <= 1;
    LINK_SPEED_100 <= 1;
    LINK_FULL_DUPLEX <= 1;
    bus(1, 8'h24, 32'h01110770);
    cyc(6);
    `CHK({SPEED_LED_N, LINK_ACTIVITY_LED_N, DUPLEX_LED_N, PIN_OUT}, 6'b001001)
    LINK_ACTIVITY <= 1;
    cyc(6);
    `CHK({LINK_ACTIVITY_LED_N, DUPLEX_LED_N, PIN_OUT}, 5'b10010)
    bus(1, 8'h24, 32'h81110770);
    cyc(6);
    `CHK({LINK_ACTIVITY_LED_N, DUPLEX_LED_N, PIN_OUT}, 5'b00000)
  endtask

  initial begin
    cyc(16);
    RESETN <= 1;
    cyc(3);
    bus(0, 8'h24, 32'h0);
    `CHK(q, 32'h80000007)
    `CHK(PIN_OE, 3'h0)
    s_fields();
    mir(32'h02320770, 4'h1, 0, 1, 3'b110);
    mir(32'h02330770, 4'h0, 1, 0, 3'b001);
    mir(32'h03220770, 4'h5, 0, 1, 3'b001);
    s_drive();
    s_event();
    s_led();
    conclude();
  end
endmodule // tb_led_gpio_pin_config
